// file: logic/mac_tx_and_size_statistics.sv
// Purpose: transmit, collision, frame-size and utilisation counters beside a 10/100 mac
// Assumes: engine reports arrive on mclk_in as single-cycle pulses, no crossing needed
// Notes:   counters wrap; software reads them over the plain register port
//
// Notes on behaviour
// R01: count deferred frames sent cleanly without collision
// R02: count every transmit collision, including late ones; code counts only collisions without carrier loss or underrun
// R03: half-duplex flow-control reception start counts collision
// R04: one non-late collision then success counts single
// R05: two to fifteen collisions then success count multiple
// R06: sixteenth collision abandons frame, counts excessive; code counts it only without carrier loss or underrun
// R07: late collision abandons frame, counts late
// R08: late collision excluded from single, multiple, excessive
// R09: late count ignores carrier loss and underrun
// R10: count every frame that starved the fifo
// R11: count carrier loss, frame not retransmitted
// R12: good transmit bytes added to byte counter
// R13: 64-byte bucket, including carrier-cut transmit frames
// R14: middle buckets exclude failed transmit frames
// R15: large bucket runs to configured maximum length
// R16: buckets ignore receive errors and overruns
// R17: utilisation adds all received and transmitted bytes
// R18: utilisation adds bytes of every failed attempt
// R19: received bytes counted only up to jam
// R20: utilisation ignores all error conditions
// R21: collision family counters ignore crc errors
// R22: pause frames count as 64-byte frames
// R23: counters readable, zero after reset, single increment
`timescale 1ns/1ps
`default_nettype none

module mac_tx_and_size_statistics #(
    parameter int unsigned CNT_W = 32
) (
    // clock and reset
    input  wire logic                             mclk_in,
    input  wire logic                             srst_in,
    // engine reports
    input  wire stats_pkg::tx_attempt_type        tx_report_in,
    input  wire stats_pkg::rx_frame_type          rx_report_in,
    // register port
    input  wire logic [stats_pkg::ADDR_W-1:0]     reg_addr_in,
    input  wire logic [stats_pkg::DATA_W-1:0]     reg_wdata_in,
    input  wire logic                             reg_wr_in,
    input  wire logic                             reg_rd_in,
    output logic      [stats_pkg::DATA_W-1:0]     reg_rdata_out,
    // to the transmit engine
    output logic                                  tx_abandon_out
);

    // ****************************************
    // decoding helpers
    // ****************************************
    // size bucket one-hot for a frame length against the receive limit
    function automatic logic [stats_pkg::NUM_BUCKET-1:0] size_bucket(
        input logic [stats_pkg::LEN_W-1:0] len,
        input logic [stats_pkg::LEN_W-1:0] max_len
    );
        logic [stats_pkg::NUM_BUCKET-1:0] hit;
        hit    = '0;
        hit[0] = (len == stats_pkg::MIN_FRAME_BYTES);
        hit[1] = (len >= stats_pkg::B_LO) && (len < stats_pkg::C_LO);
        hit[2] = (len >= stats_pkg::C_LO) && (len < stats_pkg::D_LO);
        hit[3] = (len >= stats_pkg::D_LO) && (len < stats_pkg::E_LO);
        hit[4] = (len >= stats_pkg::E_LO) && (len < stats_pkg::LARGE_LO);
        hit[5] = (len >= stats_pkg::LARGE_LO) && (len <= max_len);
        return hit;
    endfunction : size_bucket

    // ****************************************
    // state
    // ****************************************
    logic [CNT_W-1:0]             cnt_q [stats_pkg::NUM_CNT];
    logic [CNT_W-1:0]             inc_d [stats_pkg::NUM_CNT];
    logic [4:0]                   colls_q;   // non-late collisions of the current frame
    logic [stats_pkg::LEN_W-1:0]  max_len_q;
    logic [stats_pkg::DATA_W-1:0] rdata_q;
    logic                         abandon_q;

    // ****************************************
    // transmit attempt classification
    // ****************************************
    logic                         tx_v;
    logic                         tx_clean;
    logic                         tx_coll;
    logic                         tx_late;
    logic                         tx_early_coll;
    logic                         tx_excessive;
    logic                         tx_success;
    logic                         tx_done;
    logic                         tx_hist_ok;
    logic [stats_pkg::LEN_W-1:0]  tx_len;
    logic [stats_pkg::NUM_BUCKET-1:0] tx_bucket;
    logic [stats_pkg::NUM_BUCKET-1:0] rx_bucket;

    // R22 pause frames 64 bytes
    assign tx_len        = tx_report_in.pause ? stats_pkg::MIN_FRAME_BYTES : tx_report_in.bytes;
    assign tx_v          = tx_report_in.valid;
    // R21 crc never looked at
    assign tx_clean      = !tx_report_in.carrier_lost && !tx_report_in.underrun;
    assign tx_coll       = tx_v && tx_report_in.collision;
    // R07 late collision detect
    assign tx_late       = tx_coll && tx_report_in.late;
    assign tx_early_coll = tx_coll && !tx_report_in.late;
    // R06 sixteenth collision
    assign tx_excessive  = tx_early_coll && (colls_q == stats_pkg::MAX_RETRY_COLL);
    // R11 carrier loss bars success; frame end follows a collision-free report, a late collision or an excessive collision only
    assign tx_success    = tx_v && !tx_report_in.collision && tx_clean;
    assign tx_done       = tx_v && (!tx_report_in.collision || tx_late || tx_excessive);
    // R13 carrier-cut frame kept only at 64
    assign tx_hist_ok    = tx_v && !tx_report_in.collision && !tx_report_in.underrun &&
                           (!tx_report_in.carrier_lost || (tx_len == stats_pkg::MIN_FRAME_BYTES));
    // R16 receive buckets take every valid frame from 64 bytes up; only the large bucket stops at the limit
    assign rx_bucket     = rx_report_in.valid ? size_bucket(rx_report_in.bytes, max_len_q) : '0;
    assign tx_bucket     = tx_hist_ok ? size_bucket(tx_len, max_len_q) : '0;

    // ****************************************
    // collision bookkeeping
    // ****************************************
    // count non-late collisions, clear when the frame ends
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            colls_q <= 5'h00;
        end else if (tx_done) begin
            colls_q <= 5'h00;
        end else if (tx_early_coll) begin
            colls_q <= colls_q + 5'h01;
        end
    end

    // R07 abandon on late or excessive
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            abandon_q <= 1'b0;
        end else begin
            abandon_q <= tx_late || tx_excessive;
        end
    end

    // ****************************************
    // increment amounts
    // ****************************************
    // one amount per counter, zero when nothing qualifies
    always_comb begin
        for (int i = 0; i < stats_pkg::NUM_CNT; i++) begin
            inc_d[i] = '0;
        end
        // R01 deferred clean first try
        inc_d[stats_pkg::IDX_DEFER]   = CNT_W'(tx_success && (colls_q == 5'h00) && tx_report_in.deferred);
        // R02 R03 collision events
        inc_d[stats_pkg::IDX_COLL]    = CNT_W'(tx_coll && tx_clean) + CNT_W'(rx_report_in.fc_collide);
        // R04 single collision
        inc_d[stats_pkg::IDX_ONE]     = CNT_W'(tx_success && (colls_q == 5'h01));
        // R05 multiple collisions
        inc_d[stats_pkg::IDX_SEVERAL] = CNT_W'(tx_success && (colls_q >= stats_pkg::SEVERAL_LO));
        // R06 R08 excessive, never after late
        inc_d[stats_pkg::IDX_ABANDON] = CNT_W'(tx_excessive && tx_clean);
        // R09 late counted unconditionally
        inc_d[stats_pkg::IDX_LATE]    = CNT_W'(tx_late);
        // R10 fifo starve
        inc_d[stats_pkg::IDX_STARVE]  = CNT_W'(tx_v && tx_report_in.underrun);
        // R11 carrier loss
        inc_d[stats_pkg::IDX_CARRIER] = CNT_W'(tx_v && tx_report_in.carrier_lost);
        // R12 good transmit bytes
        inc_d[stats_pkg::IDX_GOOD]    = tx_success ? CNT_W'(tx_len) : '0;
        // R13 R14 R15 shared buckets
        for (int b = 0; b < stats_pkg::NUM_BUCKET; b++) begin
            inc_d[stats_pkg::IDX_BUCKET0 + b] = CNT_W'(rx_bucket[b]) + CNT_W'(tx_bucket[b]);
        end
        // R17 R18 R19 R20 wire utilisation
        inc_d[stats_pkg::IDX_WIRE]    = (tx_v ? CNT_W'(tx_len) : '0) +
                                        (rx_report_in.valid ? CNT_W'(rx_report_in.bytes) : '0);
    end

    // ****************************************
    // counters
    // ****************************************
    // R23 zero after reset, one step per event
    generate
        for (genvar g = 0; g < stats_pkg::NUM_CNT; g++) begin : g_cnt
            always_ff @(posedge mclk_in) begin
                if (srst_in) begin
                    cnt_q[g] <= '0;
                end else begin
                    cnt_q[g] <= cnt_q[g] + inc_d[g];
                end
            end
        end
    endgenerate

    // ****************************************
    // register port
    // ****************************************
    // R15 writable receive limit
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            max_len_q <= stats_pkg::MAX_LEN_RESET;
        end else if (reg_wr_in && (reg_addr_in == stats_pkg::MAX_LEN_ADDR)) begin
            max_len_q <= reg_wdata_in[stats_pkg::LEN_W-1:0];
        end
    end

    // R23 read data valid one cycle after strobe
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            rdata_q <= '0;
        end else if (!reg_rd_in) begin
            rdata_q <= '0;
        end else if (reg_addr_in == stats_pkg::MAX_LEN_ADDR) begin
            rdata_q <= {{(stats_pkg::DATA_W - stats_pkg::LEN_W){1'b0}}, max_len_q};
        end else if ((reg_addr_in[1:0] == 2'h0) && (reg_addr_in < stats_pkg::MAX_LEN_ADDR)) begin
            rdata_q <= stats_pkg::DATA_W'(cnt_q[reg_addr_in[5:2]]);
        end else begin
            rdata_q <= '0;  // unmapped reads as zero
        end
    end

    assign reg_rdata_out  = rdata_q;
    assign tx_abandon_out = abandon_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (srst_in);

    logic past_valid_q;
    always_ff @(posedge mclk_in) begin
        if (srst_in) begin
            past_valid_q <= 1'b0;
        end else begin
            past_valid_q <= 1'b1;
        end
    end

    property p_defer_count;
        past_valid_q && tx_report_in.valid && !tx_report_in.collision && !tx_report_in.carrier_lost &&
        !tx_report_in.underrun && tx_report_in.deferred && (colls_q == 5'h00)
        |=> cnt_q[stats_pkg::IDX_DEFER] == $past(cnt_q[stats_pkg::IDX_DEFER]) + CNT_W'(1);
    endproperty
    a_defer_count: assert property (p_defer_count) else $error("deferred frame not counted"); // R01

    property p_coll_count;
        tx_report_in.valid && tx_report_in.collision && !tx_report_in.carrier_lost &&
        !tx_report_in.underrun && rx_report_in.fc_collide
        |=> cnt_q[stats_pkg::IDX_COLL] == $past(cnt_q[stats_pkg::IDX_COLL]) + CNT_W'(2);
    endproperty
    a_coll_count: assert property (p_coll_count) else $error("collision events miscounted"); // R02

    property p_fc_coll;
        !tx_report_in.valid && rx_report_in.fc_collide
        |=> cnt_q[stats_pkg::IDX_COLL] == $past(cnt_q[stats_pkg::IDX_COLL]) + CNT_W'(1);
    endproperty
    a_fc_coll: assert property (p_fc_coll) else $error("flow-control collision not counted"); // R03

    property p_single;
        tx_success && (colls_q == 5'h01)
        |=> cnt_q[stats_pkg::IDX_ONE] == $past(cnt_q[stats_pkg::IDX_ONE]) + CNT_W'(1)
            && $stable(cnt_q[stats_pkg::IDX_SEVERAL]);
    endproperty
    a_single: assert property (p_single) else $error("single collision frame miscounted"); // R04

    property p_several;
        tx_success && (colls_q >= 5'h02)
        |=> cnt_q[stats_pkg::IDX_SEVERAL] == $past(cnt_q[stats_pkg::IDX_SEVERAL]) + CNT_W'(1)
            && $stable(cnt_q[stats_pkg::IDX_ONE]);
    endproperty
    a_several: assert property (p_several) else $error("multiple collision frame miscounted"); // R05

    property p_excessive;
        tx_report_in.valid && tx_report_in.collision && !tx_report_in.late && (colls_q == 5'h0f)
        |=> tx_abandon_out && (colls_q == 5'h00);
    endproperty
    a_excessive: assert property (p_excessive) else $error("sixteenth collision did not abandon"); // R06

    property p_late;
        tx_report_in.valid && tx_report_in.collision && tx_report_in.late
        |=> tx_abandon_out && (cnt_q[stats_pkg::IDX_LATE] == $past(cnt_q[stats_pkg::IDX_LATE]) + CNT_W'(1));
    endproperty
    a_late: assert property (p_late) else $error("late collision not handled"); // R07

    property p_late_only;
        tx_report_in.valid && tx_report_in.collision && tx_report_in.late
        |=> $stable(cnt_q[stats_pkg::IDX_ONE]) && $stable(cnt_q[stats_pkg::IDX_SEVERAL]) &&
            $stable(cnt_q[stats_pkg::IDX_ABANDON]) && (colls_q == 5'h00);
    endproperty
    a_late_only: assert property (p_late_only) else $error("late collision leaked into other counts"); // R08

    property p_starve;
        tx_report_in.valid && tx_report_in.underrun
        |=> cnt_q[stats_pkg::IDX_STARVE] == $past(cnt_q[stats_pkg::IDX_STARVE]) + CNT_W'(1);
    endproperty
    a_starve: assert property (p_starve) else $error("underrun not counted"); // R10

    property p_good_bytes;
        tx_success |=> cnt_q[stats_pkg::IDX_GOOD] == $past(cnt_q[stats_pkg::IDX_GOOD]) + CNT_W'($past(tx_len));
    endproperty
    a_good_bytes: assert property (p_good_bytes) else $error("good byte count wrong"); // R12

    property p_pause_bucket;
        tx_report_in.valid && tx_report_in.pause && !tx_report_in.collision &&
        !tx_report_in.underrun && !rx_report_in.valid
        |=> cnt_q[stats_pkg::IDX_BUCKET0] == $past(cnt_q[stats_pkg::IDX_BUCKET0]) + CNT_W'(1);
    endproperty
    a_pause_bucket: assert property (p_pause_bucket) else $error("pause frame missed 64 bucket"); // R22

    property p_read_once;
        reg_rd_in && (reg_addr_in == stats_pkg::MAX_LEN_ADDR) && !reg_wr_in
        |=> reg_rdata_out == {16'h0000, $past(max_len_q)} ##1 ($past(reg_rd_in) || reg_rdata_out == '0);
    endproperty
    a_read_once: assert property (p_read_once) else $error("read data timing wrong"); // R23

    c_retry_success: cover property (tx_success && colls_q == 5'h03);
    c_excessive:     cover property (tx_excessive);
    c_both_buckets:  cover property (|(rx_bucket & tx_bucket));
    c_late_after:    cover property (tx_late && colls_q != 5'h00);

endmodule : mac_tx_and_size_statistics

`default_nettype wire

// file: logic/stats_pkg.sv
// Purpose: shared constants and carriers for the transmit and frame-size statistics block
// Assumes: one clock domain; engines report events on the same clock
// Notes:   counter offsets are byte addresses on a 32-bit register port
package stats_pkg;

    // ****************************************
    // register map
    // ****************************************
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;
    localparam int unsigned LEN_W       = 16;
    localparam int unsigned NUM_CNT     = 16;
    localparam logic [7:0]  CNT_BASE    = 8'h00;  // counters at base + 4 * index
    localparam logic [7:0]  MAX_LEN_ADDR = 8'h40; // max_rx_frame_length, read/write

    // counter indexes
    localparam int unsigned IDX_DEFER    = 0;  // tx_deferred_count
    localparam int unsigned IDX_COLL     = 1;  // tx_collision_events
    localparam int unsigned IDX_ONE      = 2;  // tx_one_collision_count
    localparam int unsigned IDX_SEVERAL  = 3;  // tx_several_collision_count
    localparam int unsigned IDX_ABANDON  = 4;  // tx_abandoned_collision_count
    localparam int unsigned IDX_LATE     = 5;  // tx_late_collision_count
    localparam int unsigned IDX_STARVE   = 6;  // tx_fifo_starve_count
    localparam int unsigned IDX_CARRIER  = 7;  // tx_carrier_loss_count
    localparam int unsigned IDX_GOOD     = 8;  // tx_good_byte_count
    localparam int unsigned IDX_BUCKET0  = 9;  // size_bucket_min .. size_bucket_large
    localparam int unsigned NUM_BUCKET   = 6;
    localparam int unsigned IDX_WIRE     = 15; // wire_utilisation_bytes

    // ****************************************
    // frame sizes and limits
    // ****************************************
    localparam logic [15:0] MIN_FRAME_BYTES = 16'h0040; // 64, also the pause frame length
    localparam logic [15:0] B_LO      = 16'h0041;       // 65
    localparam logic [15:0] C_LO      = 16'h0080;       // 128
    localparam logic [15:0] D_LO      = 16'h0100;       // 256
    localparam logic [15:0] E_LO      = 16'h0200;       // 512
    localparam logic [15:0] LARGE_LO  = 16'h0400;       // 1024
    localparam logic [15:0] MAX_LEN_RESET = 16'h05ee;   // plain default, software may change
    localparam logic [4:0]  MAX_RETRY_COLL = 5'h0f;     // the 16th collision abandons
    localparam logic [4:0]  SEVERAL_LO = 5'h02;

    // ****************************************
    // carriers
    // ****************************************
    // one report per transmit attempt, pulse on valid
    typedef struct packed {
        logic        valid;        // attempt ended this cycle
        logic        deferred;     // medium was busy when the attempt began
        logic        collision;    // attempt ended by a collision
        logic        late;         // that collision came after 512 bit-times
        logic        carrier_lost; // carrier lost or never seen
        logic        underrun;     // transmit fifo ran empty
        logic        pause;        // self-made pause frame, length forced to 64
        logic [15:0] bytes;        // bytes put on the wire in this attempt
    } tx_attempt_type;

    // one report per received frame, plus half-duplex flow-control start
    typedef struct packed {
        logic        valid;        // frame finished this cycle
        logic        fc_collide;   // reception began under half-duplex flow control
        logic [15:0] bytes;        // bytes received, up to any flow-control jam
    } rx_frame_type;

endpackage : stats_pkg

// file: dv/engine_model.sv
// Purpose: stand-in for the mac transmit and receive engines that feed the counters
// Assumes: one report per call, driven by non-blocking assignment just after a rising edge
// Notes:   idle fields carry inverted data so nothing can lean on stale values
`timescale 1ns/1ps
`default_nettype none

module engine_model (
    // clock
    input  wire logic                     mclk_in,
    // reports towards the counters
    output var stats_pkg::tx_attempt_type tx_report_out,
    output var stats_pkg::rx_frame_type   rx_report_out
);
    // ****************************************
    // report drivers
    // ****************************************
    // quiet reports from time zero
    initial begin
        tx_report_out = '0;
        rx_report_out = '0;
    end

    // one transmit attempt, keep leaves valid up for a back-to-back follower
    task automatic send_tx(input stats_pkg::tx_attempt_type r, input bit keep);
        @(posedge mclk_in);
        tx_report_out <= r;
        if (!keep) begin
            @(posedge mclk_in);
            tx_report_out <= ~r & 23'h3fffff; // valid low, side fields scrambled
        end
    endtask : send_tx

    // one receive report, frame end and flow-control start pulses
    task automatic send_rx(input bit fc, input bit valid, input logic [15:0] len);
        @(posedge mclk_in);
        rx_report_out <= {valid, fc, len};
        @(posedge mclk_in);
        rx_report_out <= {2'b00, ~len};
    endtask : send_rx
endmodule : engine_model
`default_nettype wire

// file: dv/tb_top.sv
// Purpose: self-checking bench for the transmit and frame-size counters
// Assumes: engine_model drives the reports, the bench drives the register port
// Notes:   a small reference model keeps the expected counter values
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    // ****************************************
    // signals and reference state
    // ****************************************
    localparam logic [5:0] DEF = 6'h20; // flags: deferred collision late carrier underrun pause
    localparam logic [5:0] COL = 6'h10;
    localparam logic [5:0] LATE = 6'h08;
    localparam logic [5:0] CAR = 6'h04;
    localparam logic [5:0] UND = 6'h02;
    localparam logic [5:0] PAU = 6'h01;
    logic                           mclk_in;
    logic                           srst_in;
    logic [7:0]                     reg_addr;
    logic [31:0]                    reg_wdata;
    logic                           reg_wr;
    logic                           reg_rd;
    logic [31:0]                    reg_rdata;
    logic                           abandon;
    wire stats_pkg::tx_attempt_type tx_rep;
    wire stats_pkg::rx_frame_type   rx_rep;
    logic [31:0]                    exp_cnt [16];
    logic [15:0]                    max_len;
    int                             tally, exp_abandon, abandon_seen, cycles, err_count, n_checks;

    // ****************************************
    // partner and design
    // ****************************************
    engine_model partner (.mclk_in(mclk_in), .tx_report_out(tx_rep), .rx_report_out(rx_rep));
    mac_tx_and_size_statistics uut (.mclk_in(mclk_in), .srst_in(srst_in), .tx_report_in(tx_rep),
        .rx_report_in(rx_rep), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_wr_in(reg_wr),
        .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .tx_abandon_out(abandon));

    // free-running clock
    initial begin
        mclk_in = 1'b0;
        forever #2 mclk_in = ~mclk_in;
    end

    // cycle count, abandon pulses and hang guard
    always @(posedge mclk_in) begin
        cycles <= cycles + 1;
        if (abandon === 1'b1) begin
            abandon_seen <= abandon_seen + 1;
        end
        if (cycles == 20000) begin
            err_count++;
            give_verdict();
        end
    end

    // ****************************************
    // checking and bus tasks
    // ****************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : give_verdict

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk_in);
        reg_wr    <= 1'b0;
    endtask : reg_write

    // read data stand only in the cycle after the strobe
    task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk_in);
        reg_rd   <= 1'b0;
        #1 d = reg_rdata;
    endtask : reg_read

    task automatic check_all();
        logic [31:0] d;
        for (int i = 0; i < 16; i++) begin
            reg_read(8'(4 * i), d);
            check($sformatf("counter %0d", i), d, exp_cnt[i]);
        end
        check("abandon pulses", 32'(abandon_seen), 32'(exp_abandon));
    endtask : check_all

    // ****************************************
    // reference model
    // ****************************************
    function automatic int bucket_of(logic [15:0] len);
        if (len < 16'h0040 || len > max_len) return -1;
        if (len == 16'h0040) return 9;
        if (len < 16'h0080) return 10;
        if (len < 16'h0100) return 11;
        if (len < 16'h0200) return 12;
        if (len < 16'h0400) return 13;
        return 14;
    endfunction : bucket_of

    // one attempt report: send it and book its expected effect
    task automatic send(input logic [5:0] f, input logic [15:0] len, input bit keep);
        stats_pkg::tx_attempt_type r;
        bit                        clean;
        int                        b;
        r = {1'b1, f, len};
        clean = !r.carrier_lost && !r.underrun;
        if (r.pause) begin
            len = 16'h0040;
        end
        b = bucket_of(len);
        exp_cnt[15] += len;
        exp_cnt[6] += r.underrun;
        exp_cnt[7] += r.carrier_lost;
        if (r.collision) begin
            exp_cnt[1] += clean;
            exp_cnt[5] += r.late;
            exp_cnt[4] += (!r.late && tally == 15 && clean);
            exp_abandon += (r.late || tally == 15);
            tally = (r.late || tally == 15) ? 0 : tally + 1;
        end else begin
            exp_cnt[8] += clean ? 32'(len) : 32'h0;
            exp_cnt[0] += (clean && tally == 0 && r.deferred);
            exp_cnt[2] += (clean && tally == 1);
            exp_cnt[3] += (clean && tally > 1);
            if (!r.underrun && (!r.carrier_lost || len == 16'h0040) && b >= 0) begin
                exp_cnt[b]++;
            end
            tally = 0;
        end
        partner.send_tx(r, keep);
    endtask : send

    task automatic rx(input bit fc, input bit valid, input logic [15:0] len);
        exp_cnt[1] += fc;
        exp_cnt[15] += valid ? 32'(len) : 32'h0;
        if (valid && bucket_of(len) >= 0) begin
            exp_cnt[bucket_of(len)]++;
        end
        partner.send_rx(fc, valid, len);
    endtask : rx

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_reset();
        logic [31:0] d;
        check_all();
        reg_read(8'h40, d);
        check("max length", d, 32'h000005ee);
        reg_write(8'h00, 32'hffffffff);
        reg_read(8'h44, d);
        check("unmapped", d, 32'h0);
        reg_read(8'h41, d);
        check("misaligned", d, 32'h0);
        check_all();
    endtask : t_reset

    task automatic t_collisions();
        send(COL, 16'h0028, 1);
        send(6'h00, 16'h0064, 0);
        send(DEF, 16'h0040, 0);
        send(DEF | COL, 16'h001e, 1);
        send(DEF, 16'h00c8, 0);
        check_all();
        for (int n = 2; n <= 15; n += 13) begin
            repeat (n) send(COL, 16'h0030, 1);
            send(6'h00, 16'h012c, 0);
        end
        repeat (16) send(COL, 16'h0020, 1);
        send(DEF, 16'h0040, 0);
        check_all();
    endtask : t_collisions

    task automatic t_faults();
        repeat (15) send(COL, 16'h0030, 1);
        send(COL | LATE | UND, 16'h0258, 1);
        send(COL | LATE | CAR, 16'h0100, 1);
        send(DEF, 16'h0050, 0);
        send(CAR, 16'h0040, 0);
        send(CAR, 16'h0064, 0);
        send(UND, 16'h0064, 0);
        check_all();
    endtask : t_faults

    task automatic t_sizes();
        logic [31:0] d;
        logic [15:0] lens [11] = '{16'h007f, 16'h0080, 16'h00ff, 16'h0100, 16'h01ff, 16'h0200,
                                   16'h03ff, 16'h0400, 16'h0500, 16'h0501, 16'h003f};
        reg_write(8'h40, 32'h00000500);
        max_len = 16'h0500;
        reg_read(8'h40, d);
        check("max length", d, 32'h00000500);
        foreach (lens[i]) rx(1'b0, 1'b1, lens[i]);
        rx(1'b1, 1'b0, 16'h0000);
        fork
            send(6'h00, 16'h0040, 0);
            rx(1'b0, 1'b1, 16'h0040);
        join
        fork
            send(COL, 16'h0030, 0);
            rx(1'b1, 1'b0, 16'h0000);
        join
        send(PAU, 16'h0100, 0);
        check_all();
    endtask : t_sizes

    // mid-run reset clears counters, limit and retry tally
    task automatic t_rerun();
        logic [31:0] d;
        send(COL, 16'h0030, 0);
        @(posedge mclk_in);
        srst_in <= 1'b1;
        repeat (2) @(posedge mclk_in);
        srst_in <= 1'b0;
        foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
        tally = 0;
        max_len = 16'h05ee;
        @(posedge mclk_in);
        send(6'h00, 16'h0064, 0);
        reg_read(8'h40, d);
        check("max length", d, 32'h000005ee);
        check_all();
    endtask : t_rerun

    // reset, then the scenarios in turn
    initial begin
        srst_in = 1'b1;
        reg_addr = 8'h00;
        reg_wdata = 32'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        max_len = 16'h05ee;
        {tally, exp_abandon, abandon_seen, cycles, err_count, n_checks} = '0;
        foreach (exp_cnt[i]) exp_cnt[i] = 32'h0;
        repeat (5) @(posedge mclk_in);
        srst_in <= 1'b0;
        @(posedge mclk_in);
        t_reset();
        t_collisions();
        t_faults();
        t_sizes();
        t_rerun();
        give_verdict();
    end
endmodule : tb_top
`default_nettype wire
